// ---- rtl/spdp_core.sv ----
// Serial-programmed divider, pulse-swallow control and phase comparator.
// Assumes serial, polarity and rate pin inputs are asynchronous to CLK; APB, reset and enable are synchronous; pad pull-ups sit outside.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps

// Behaviour
// - Main path: 19-bit shifter, 18-bit latch, 7-bit swallow, 11-bit main counter.
// - Swallow field is low seven main-word bits, binary 0..127.
// - Last bit picks latch: low main 18-bit, high reference 15-bit.
// - Each serial clock rising edge shifts exactly one data bit.
// - While load strobe is high, shifter copies into selected latch.
// - One serial clock drives both main and reference shifters.
// - Division is modulus times main plus swallow; modulus 64 or 128.
// - Reference counter is 14-bit binary divider, 8 to 16383.
// - Normal polarity pump, ref-side, pump-side patterns per rate relation.
// - Reversed polarity swaps the faster and slower patterns.
// - Monitor shows reference rate normally, main rate when reversed.
// - Comparator tracks phase error from -2pi to +2pi.
// - At phase equality brief spikes remove the dead band.
// - Fast-lock pin carries pump while strobe high, floats otherwise.
// - Lock indicator high when locked, low when unlocked.
// - Unconnected polarity select reads high, normal polarity.
// - Reference word holds 14-bit count plus ratio bit; below 8 prohibited.
// - Ratio bit low selects modulus pair 128/129, high 64/65.
// - Unconnected load strobe reads high and loads the latch.
module spdp_core
  import spdp_pkg::*;
#(
  parameter int LOCK_COMPARES = 8
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // Serial programming pins
  input wire logic SER_DATA,
  input wire logic SER_CLK,
  input wire logic LOAD_STROBE,
  input wire logic PHASE_POLARITY_SELECT,
  // Rate inputs
  input wire logic OSC_IN,
  input wire logic PRESCALER_IN,
  // Prescaler control
  output logic PRESCALER_PLUS_ONE,
  output logic PRESCALER_MOD64,
  // Pump and comparator pins
  output logic PUMP_OUT,
  output logic PUMP_OE,
  output logic REF_SIDE_OUT,
  output logic PUMP_SIDE_OUT,
  output logic PUMP_SIDE_OE,
  output logic FAST_LOCK_SWITCH_OUT,
  output logic FAST_LOCK_SWITCH_OE,
  output logic LOCK_INDICATOR_OUT,
  output logic DIVIDER_MONITOR_OUT,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  if (LOCK_COMPARES < 1 || LOCK_COMPARES >= (1 << GOOD_W)) begin : g_chk
    $error("LOCK_COMPARES out of range");
  end

  localparam logic [GOOD_W-1:0] GOOD_MAX = GOOD_W'(LOCK_COMPARES);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic data_m, data_s;
    logic sclk_m, sclk_s, sclk_d;
    logic strobe_m, strobe_s, strobe_d;
    logic pol_m, pol_s, pol_d;
    logic osc_m, osc_s, osc_d;
    logic vco_m, vco_s, vco_d;
    logic [MAIN_SR_W-1:0] sr_main;
    logic [REF_SR_W-1:0] sr_ref;
    logic [MAIN_LAT_W-1:0] main_lat;
    logic [REF_LAT_W-1:0] ref_lat;
    logic [SWAL_W-1:0] swal_cnt;
    logic [MAIN_W-1:0] main_cnt;
    logic [REF_W-1:0] ref_cnt;
    logic mod64;
    logic ref_pulse, main_pulse;
    logic up, dn, spike;
    logic [ERR_W-1:0] err_cnt;
    logic [GOOD_W-1:0] good_cnt;
    logic locked;
    logic [ERR_W-1:0] lock_tol;
    logic pready, pslverr;
    logic [31:0] prdata;
    logic pump_out, pump_oe, ref_side, pside_oe;
    logic fl_out, fl_oe, mon, plus_one, lock;
  } spdp_state_t;

  spdp_state_t st, next_st;

  function automatic logic rise(input logic now, input logic old);
    return now & ~old;
  endfunction

  function automatic logic mapped(input logic [APB_AW-1:0] a);
    return a == OFS_STATUS || a == OFS_MAIN || a == OFS_REF || a == OFS_LOCK_TOL;
  endfunction

  logic sclk_rise, osc_rise, vco_rise, a_side, b_side;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // Pin synchronisers
    next_st.data_m = SER_DATA;
    next_st.data_s = st.data_m;
    next_st.sclk_m = SER_CLK;
    next_st.sclk_s = st.sclk_m;
    next_st.sclk_d = st.sclk_s;
    next_st.strobe_m = LOAD_STROBE;
    next_st.strobe_s = st.strobe_m;
    next_st.strobe_d = st.strobe_s;
    next_st.pol_m = PHASE_POLARITY_SELECT;
    next_st.pol_s = st.pol_m;
    next_st.pol_d = st.pol_s;
    next_st.osc_m = OSC_IN;
    next_st.osc_s = st.osc_m;
    next_st.osc_d = st.osc_s;
    next_st.vco_m = PRESCALER_IN;
    next_st.vco_s = st.vco_m;
    next_st.vco_d = st.vco_s;
    sclk_rise = rise(st.sclk_s, st.sclk_d);
    osc_rise = rise(st.osc_s, st.osc_d);
    vco_rise = rise(st.vco_s, st.vco_d);

    // Serial shifters share one serial clock, one bit per edge
    if (sclk_rise) begin
      next_st.sr_main = {st.sr_main[MAIN_SR_W-2:0], st.data_s};
      next_st.sr_ref = {st.sr_ref[REF_SR_W-2:0], st.data_s};
    end
    // Level-sensitive load, steered by the destination bit
    if (st.strobe_s) begin
      if (st.sr_main[DEST_POS]) begin
        next_st.ref_lat = st.sr_ref[REF_SR_W-1:1];
      end else begin
        next_st.main_lat = st.sr_main[MAIN_SR_W-1:1];
      end
    end

    // Reference divider
    next_st.ref_pulse = 1'b0;
    if (osc_rise) begin
      if (st.ref_cnt <= 14'h0001) begin
        next_st.ref_cnt = st.ref_lat[REF_W-1:0];
        next_st.ref_pulse = 1'b1;
      end else begin
        next_st.ref_cnt = st.ref_cnt - 14'h0001;
      end
    end

    // Pulse-swallow main divider
    next_st.main_pulse = 1'b0;
    if (vco_rise) begin
      if (st.swal_cnt != 7'h00) begin
        next_st.swal_cnt = st.swal_cnt - 7'h01;
      end
      if (st.main_cnt <= 11'h001) begin
        next_st.main_cnt = st.main_lat[MAIN_LSB +: MAIN_W];
        next_st.swal_cnt = st.main_lat[SWAL_LSB +: SWAL_W];
        next_st.mod64 = st.ref_lat[RATIO_POS];
        next_st.main_pulse = 1'b1;
      end else begin
        next_st.main_cnt = st.main_cnt - 11'h001;
      end
    end
    next_st.plus_one = next_st.swal_cnt != 7'h00;

    // Phase/frequency comparator with +-2pi range
    next_st.spike = 1'b0;
    next_st.up = st.up | st.ref_pulse;
    next_st.dn = st.dn | st.main_pulse;
    if (next_st.up && next_st.dn) begin
      next_st.up = 1'b0;
      next_st.dn = 1'b0;
      next_st.spike = 1'b1;
    end

    // Lock detection: error width per comparison against tolerance
    if (next_st.spike) begin
      next_st.err_cnt = '0;
      if (st.err_cnt <= st.lock_tol) begin
        if (st.good_cnt != GOOD_MAX) begin
          next_st.good_cnt = st.good_cnt + 8'h01;
        end
      end else begin
        next_st.good_cnt = '0;
      end
    end else if (st.up || st.dn) begin
      if (st.err_cnt != {ERR_W{1'b1}}) begin
        next_st.err_cnt = st.err_cnt + 16'h0001;
      end
      if (st.err_cnt > st.lock_tol) begin
        next_st.good_cnt = '0;
      end
    end
    next_st.locked = next_st.good_cnt == GOOD_MAX;
    next_st.lock = next_st.locked;

    // Output patterns; polarity swaps which side drives the high pattern
    a_side = next_st.pol_d ? next_st.up : next_st.dn;
    b_side = next_st.pol_d ? next_st.dn : next_st.up;
    next_st.pump_out = a_side;
    next_st.pump_oe = a_side | b_side;
    next_st.ref_side = b_side | next_st.spike;
    next_st.pside_oe = a_side | next_st.spike;
    next_st.fl_out = next_st.pump_out;
    next_st.fl_oe = next_st.strobe_d & next_st.pump_oe;
    next_st.mon = next_st.pol_d ? next_st.ref_pulse : next_st.main_pulse;

    // APB slave: one wait state, answer registered
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (PSEL && PENABLE && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !mapped(PADDR);
      next_st.prdata = '0;
      if (!PWRITE) begin
        unique case (PADDR)
          OFS_STATUS: begin
            next_st.prdata[ST_LOCK] = st.locked;
            next_st.prdata[ST_POL] = st.pol_s;
            next_st.prdata[ST_UP] = st.up;
            next_st.prdata[ST_DN] = st.dn;
            next_st.prdata[ST_STROBE] = st.strobe_s;
          end
          OFS_MAIN: next_st.prdata[MAIN_LAT_W-1:0] = st.main_lat;
          OFS_REF: next_st.prdata[REF_LAT_W-1:0] = st.ref_lat;
          OFS_LOCK_TOL: next_st.prdata[ERR_W-1:0] = st.lock_tol;
          default: next_st.prdata = '0;
        endcase
      end
    end
    if (PSEL && PENABLE && st.pready && PWRITE && PADDR == OFS_LOCK_TOL) begin
      next_st.lock_tol = PWDATA[ERR_W-1:0];
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st <= '0;
      st.sr_main <= {MAIN_LAT_RST, 1'b0};
      st.strobe_m <= 1'b1;
      st.strobe_s <= 1'b1;
      st.pol_m <= 1'b1;
      st.pol_s <= 1'b1;
      st.main_lat <= MAIN_LAT_RST;
      st.ref_lat <= REF_LAT_RST;
      st.lock_tol <= LOCK_TOL_RST;
    end else if (CE) begin
      st <= next_st;
    end
  end

  assign PRESCALER_PLUS_ONE = st.plus_one;
  assign PRESCALER_MOD64 = st.mod64;
  assign PUMP_OUT = st.pump_out;
  assign PUMP_OE = st.pump_oe;
  assign REF_SIDE_OUT = st.ref_side;
  assign PUMP_SIDE_OUT = 1'b0;
  assign PUMP_SIDE_OE = st.pside_oe;
  assign FAST_LOCK_SWITCH_OUT = st.fl_out;
  assign FAST_LOCK_SWITCH_OE = st.fl_oe;
  assign LOCK_INDICATOR_OUT = st.lock;
  assign DIVIDER_MONITOR_OUT = st.mon;
  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET || !CE);

  sequence s_shift_edge;
    st.sclk_s && !st.sclk_d;
  endsequence

  sequence s_main_load;
    st.strobe_s && !st.sr_main[DEST_POS];
  endsequence

  sequence s_ref_load;
    st.strobe_s && st.sr_main[DEST_POS];
  endsequence

  sequence s_ref_wrap;
    st.osc_s && !st.osc_d && st.ref_cnt <= 14'h0001;
  endsequence

  sequence s_main_wrap;
    st.vco_s && !st.vco_d && st.main_cnt <= 11'h001;
  endsequence

  a_shift_one_bit: assert property (
    s_shift_edge |=> st.sr_main == {$past(st.sr_main[MAIN_SR_W-2:0]), $past(st.data_s)}
  ) else $error("main shifter did not take one bit");

  a_shift_shared: assert property (
    s_shift_edge |=> st.sr_ref[0] == st.sr_main[0]
  ) else $error("reference shifter missed the shared edge");

  a_load_main: assert property (
    s_main_load |=> st.main_lat == $past(st.sr_main[MAIN_SR_W-1:1])
  ) else $error("main latch not loaded");

  a_load_ref: assert property (
    s_ref_load |=> st.ref_lat == $past(st.sr_ref[REF_SR_W-1:1])
  ) else $error("reference latch not loaded");

  a_ref_reload: assert property (
    s_ref_wrap |=> st.ref_pulse && st.ref_cnt == $past(st.ref_lat[REF_W-1:0])
  ) else $error("reference counter reload wrong");

  a_main_reload: assert property (
    s_main_wrap |=> st.main_pulse && st.main_cnt == $past(st.main_lat[MAIN_LSB +: MAIN_W])
      && st.swal_cnt == $past(st.main_lat[SWAL_LSB +: SWAL_W])
  ) else $error("main counters reload wrong");

  a_swallow_plus: assert property (
    PRESCALER_PLUS_ONE == (st.swal_cnt != 7'h00)
  ) else $error("modulus request does not follow swallow count");

  a_pump_normal: assert property (
    st.pol_d && st.up |-> PUMP_OUT && PUMP_OE && !REF_SIDE_OUT && PUMP_SIDE_OE
  ) else $error("normal polarity pattern wrong");
  a_pump_reversed: assert property (
    !st.pol_d && st.up |-> !PUMP_OUT && PUMP_OE && REF_SIDE_OUT && !PUMP_SIDE_OE
  ) else $error("reversed polarity pattern wrong");
  a_pump_idle: assert property (
    !st.up && !st.dn && !st.spike |-> !PUMP_OE && !REF_SIDE_OUT && !PUMP_SIDE_OE
  ) else $error("idle pattern wrong");

  a_spike_brief: assert property (
    st.spike |-> REF_SIDE_OUT && PUMP_SIDE_OE ##1 !st.spike
  ) else $error("dead-band spike wrong");

  a_monitor_sel: assert property (
    DIVIDER_MONITOR_OUT == (st.pol_d ? st.ref_pulse : st.main_pulse)
  ) else $error("monitor shows wrong rate");
  a_fast_lock: assert property (
    FAST_LOCK_SWITCH_OE == (st.strobe_d && PUMP_OE) && FAST_LOCK_SWITCH_OUT == PUMP_OUT
  ) else $error("fast-lock switch wrong");
  a_lock_out: assert property (
    LOCK_INDICATOR_OUT == (st.good_cnt == GOOD_MAX)
  ) else $error("lock indicator disagrees with lock state");
endmodule // spdp_core

// ---- rtl/spdp_pkg.sv ----
// Constants for the serial PLL divider and phase logic core.
// Assumes one system clock; all pins are sampled inside the core.
package spdp_pkg;
  // ----------------------------------------
  // Serial words and latches
  // ----------------------------------------
  localparam int MAIN_SR_W = 19;
  localparam int REF_SR_W = 16;
  localparam int MAIN_LAT_W = 18;
  localparam int REF_LAT_W = 15;
  localparam int SWAL_W = 7;
  localparam int MAIN_W = 11;
  localparam int REF_W = 14;
  localparam int SWAL_LSB = 0;
  localparam int MAIN_LSB = 7;
  localparam int RATIO_POS = 14;
  localparam int DEST_POS = 0;
  localparam logic [MAIN_LAT_W-1:0] MAIN_LAT_RST = 18'h0_0800;
  localparam logic [REF_LAT_W-1:0] REF_LAT_RST = 15'h0008;
  // ----------------------------------------
  // Lock detection
  // ----------------------------------------
  localparam int ERR_W = 16;
  localparam int GOOD_W = 8;
  localparam logic [ERR_W-1:0] LOCK_TOL_RST = 16'h0004;
  // ----------------------------------------
  // APB register map
  // ----------------------------------------
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [APB_AW-1:0] OFS_MAIN = 8'h04;
  localparam logic [APB_AW-1:0] OFS_REF = 8'h08;
  localparam logic [APB_AW-1:0] OFS_LOCK_TOL = 8'h0C;
  localparam int ST_LOCK = 0;
  localparam int ST_POL = 1;
  localparam int ST_UP = 2;
  localparam int ST_DN = 3;
  localparam int ST_STROBE = 4;
endpackage

// ---- tb/spdp_host_model.sv ----
// Host model that programs the core over the three-wire serial link.
// Assumes a free-running system clock; the link clock moves only inside frames.
`timescale 1ns/1ps
module spdp_host_model (
  // System clock
  input wire logic clk,
  // Serial link
  output logic ser_data,
  output logic ser_clk,
  output logic load_strobe
);
  initial begin
    ser_data = 1'b0;
    ser_clk = 1'b0;
    load_strobe = 1'b0;
  end
  // ----------------------------------------
  // Frame sender
  // ----------------------------------------
  task automatic send_bits(input logic [18:0] word, input int nbits);
    for (int i = nbits - 1; i >= 0; i--) begin
      @(posedge clk);
      ser_data <= word[i];
      repeat (5) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (5) @(posedge clk);
      ser_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    // Released data line shows the inverse of the last bit
    ser_data <= ~word[0];
    load_strobe <= 1'b1;
    repeat (8) @(posedge clk);
    load_strobe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic send_main(input logic [10:0] n, input logic [6:0] a);
    send_bits({n, a, 1'b0}, 19);
  endtask
  task automatic send_ref(input logic ratio, input logic [13:0] r);
    send_bits({3'h0, ratio, r, 1'b1}, 16);
  endtask
endmodule // spdp_host_model

// ---- tb/tb.sv ----
// Self-checking bench for the serial divider and phase logic core.
// Assumes the host model drives the serial pins; APB and rate inputs come from here.
`timescale 1ns/1ps
module tb;
  import spdp_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pol = 1'b1;
  logic run = 1'b0;
  logic osc_in = 1'b0;
  logic pre_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic ser_data, ser_clk, load_strobe, pready, pslverr, plus_one, mod64;
  logic pump_out, pump_oe, ref_side, pside_out, pside_oe, fl_out, fl_oe, lock_out, mon_out;
  logic exp_pump = 1'b1;
  logic chk_pump = 1'b0;
  logic [7:0] stb_hist = '0;
  int pre_half = 2;
  int oc = 0;
  int pc = 0;
  int n_errors = 0;
  int num_checks = 0;
  int mon_cnt = 0, plus_cnt = 0, pump_bad = 0, pump_on = 0, fl_bad = 0, fl_on = 0;
  integer seed = 32'h0000_1f6b;

  initial begin
    forever #4 clk = ~clk;
  end

  spdp_core #(.LOCK_COMPARES(2)) u_spdp_core (
    .CLK(clk), .RESET(reset), .CE(1'b1),
    .SER_DATA(ser_data), .SER_CLK(ser_clk), .LOAD_STROBE(load_strobe),
    .PHASE_POLARITY_SELECT(pol), .OSC_IN(osc_in), .PRESCALER_IN(pre_in),
    .PRESCALER_PLUS_ONE(plus_one), .PRESCALER_MOD64(mod64),
    .PUMP_OUT(pump_out), .PUMP_OE(pump_oe), .REF_SIDE_OUT(ref_side),
    .PUMP_SIDE_OUT(pside_out), .PUMP_SIDE_OE(pside_oe),
    .FAST_LOCK_SWITCH_OUT(fl_out), .FAST_LOCK_SWITCH_OE(fl_oe),
    .LOCK_INDICATOR_OUT(lock_out), .DIVIDER_MONITOR_OUT(mon_out),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  spdp_host_model u_spdp_host_model (
    .clk(clk), .ser_data(ser_data), .ser_clk(ser_clk), .load_strobe(load_strobe));

  // ----------------------------------------
  // Rate sources and monitors
  // ----------------------------------------
  // Reference edge every 4 cycles, prescaler edge every 2*pre_half cycles
  always @(posedge clk) begin
    oc <= (oc + 1) % 2;
    pc <= (pc + 1) % pre_half;
    if (run && oc == 1) osc_in <= ~osc_in;
    if (run && pc >= pre_half - 1) pre_in <= ~pre_in;
    stb_hist <= {stb_hist[6:0], load_strobe};
    if (mon_out === 1'b1) mon_cnt <= mon_cnt + 1;
    if (plus_one === 1'b1) plus_cnt <= plus_cnt + 1;
    if (chk_pump && pump_oe === 1'b1) pump_on <= pump_on + 1;
    if (chk_pump && pump_oe === 1'b1 && (pump_out !== exp_pump || ref_side !== ~exp_pump
        || pside_oe !== exp_pump || pside_out !== 1'b0)) pump_bad <= pump_bad + 1;
    if (!reset && stb_hist == 8'h00 && fl_oe !== 1'b0) fl_bad <= fl_bad + 1;
    if (stb_hist == 8'hff && fl_oe === 1'b1 && fl_out === pump_out) fl_on <= fl_on + 1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Expected latch read-back words
  function automatic logic [31:0] main_word(input int n, input int a);
    return {14'h0000, n[10:0], a[6:0]};
  endfunction

  function automatic logic [31:0] ref_word(input logic ratio, input int r);
    return {17'h0_0000, ratio, r[13:0]};
  endfunction

  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [APB_AW-1:0] a, input logic [31:0] want, input logic werr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, want);
    chk(32'(err), 32'(werr));
  endtask

  // Pulses and swallow-request cycles seen within a window
  task automatic count_win(input int cycles, output int mc, output int pcn);
    int m0;
    int p0;
    m0 = mon_cnt;
    p0 = plus_cnt;
    repeat (cycles) @(posedge clk);
    mc = mon_cnt - m0;
    pcn = plus_cnt - p0;
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic [31:0] x;
    logic err;
    logic ratio;
    int n, a, r, mc, pcn;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rchk(OFS_REF, 32'(REF_LAT_RST), 1'b0);
    rchk(OFS_MAIN, 32'(MAIN_LAT_RST), 1'b0);
    rchk(OFS_LOCK_TOL, 32'(LOCK_TOL_RST), 1'b0);
    rchk(8'h10, 32'h0000_0000, 1'b1);
    // First pass loads the largest fields with the rate inputs still
    for (int i = 0; i < 4; i++) begin
      x = $random(seed);
      n = (i == 0) ? 2047 : 16 + int'(x[4:0]);
      a = (i == 0) ? 127 : int'(x[9:5]) % n;
      r = (i == 0) ? 16383 : 8 + int'(x[12:10]);
      ratio = x[13];
      u_spdp_host_model.send_main(n[10:0], a[6:0]);
      u_spdp_host_model.send_ref(ratio, r[13:0]);
      rchk(OFS_MAIN, main_word(n, a), 1'b0);
      rchk(OFS_REF, ref_word(ratio, r), 1'b0);
      apb(1'b1, OFS_MAIN, 32'h0000_0000, rd, err);
      rchk(OFS_MAIN, main_word(n, a), 1'b0);
      if (i == 0) continue;
      run <= 1'b1;
      pol <= 1'b1;
      repeat (400) @(posedge clk);
      chk(32'(mod64), 32'(ratio));
      count_win(12 * r, mc, pcn);
      chk(32'(mc), 32'h0000_0003);
      pol <= 1'b0;
      repeat (16) @(posedge clk);
      count_win(12 * n, mc, pcn);
      chk(32'(mc), 32'h0000_0003);
      chk(32'(pcn), 32'(12 * a));
    end
    // Reference faster than main, both polarities, loads while pumping
    pre_half <= 6;
    for (int p = 1; p >= 0; p--) begin
      pol <= p[0];
      exp_pump <= p[0];
      u_spdp_host_model.send_main(11'h010, 7'h00);
      u_spdp_host_model.send_ref(1'b0, 14'h0008);
      repeat (1000) @(posedge clk);
      chk_pump <= 1'b1;
      repeat (2000) @(posedge clk);
      chk_pump <= 1'b0;
    end
    chk(32'(pump_bad), 32'h0000_0000);
    chk(32'(pump_on > 0), 32'h0000_0001);
    chk(32'(fl_bad), 32'h0000_0000);
    chk(32'(fl_on > 0), 32'h0000_0001);
    // Equal rates lock, then a drifting phase unlocks
    pre_half <= 2;
    apb(1'b1, OFS_LOCK_TOL, 32'h0000_00ff, rd, err);
    rchk(OFS_LOCK_TOL, 32'h0000_00ff, 1'b0);
    u_spdp_host_model.send_ref(1'b0, 14'h0010);
    repeat (2000) @(posedge clk);
    chk(32'(lock_out), 32'h0000_0001);
    apb(1'b1, OFS_LOCK_TOL, 32'h0000_0004, rd, err);
    pre_half <= 5;
    repeat (3000) @(posedge clk);
    chk(32'(lock_out), 32'h0000_0000);
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule // tb
